// *** verilog/bwp_pkg.sv ***
package bwp_pkg;
  // ---------------------------------------------------------------
  // Register map (word-per-register on the plain port)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_LATCH = 3'h0;
  localparam logic [2:0] ADDR_DIR = 3'h1;
  localparam logic [2:0] ADDR_OPT = 3'h2;
  localparam logic [2:0] ADDR_TRIG = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h5;
  localparam logic [2:0] ADDR_IRQ_CLR = 3'h6;
  // ---------------------------------------------------------------
  // Reset values and trigger encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_LOW = 2'h2;
  localparam logic [1:0] RST_TRIG = 2'h0;
endpackage

// *** verilog/bwp_port.sv ***
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module bwp_port #(
  // Number of lines in the port, at most eight
  parameter int WIDTH = 8,
  // One bit per line that can reach the converter multiplexer
  parameter logic [7:0] ANALOG_MASK = 8'hFF
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Pins
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_n_o,
  output logic [WIDTH-1:0] pullup_o,
  output logic [WIDTH-1:0] analog_sel_o,
  // Interrupt
  output logic [WIDTH-1:0] irq_req_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // The three port registers software sees as data space
  logic [WIDTH-1:0] pin_value_latch_r;
  logic [WIDTH-1:0] line_direction_reg_r;
  logic [WIDTH-1:0] line_option_sel_r;
  // Interrupt side registers, outside the three port registers
  logic [1:0] trig_r;
  logic [WIDTH-1:0] stat_r;
  logic [WIDTH-1:0] en_r;
  // Previous pin levels for the edge detectors
  logic [WIDTH-1:0] pin_prev_r;
  // Next status value, set and clear merged
  logic [WIDTH-1:0] stat_nxt;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  // Write strobes, one per writable register index
  wire wr_latch = wr_i && (addr_i == bwp_pkg::ADDR_LATCH);
  wire wr_dir = wr_i && (addr_i == bwp_pkg::ADDR_DIR);
  wire wr_opt = wr_i && (addr_i == bwp_pkg::ADDR_OPT);
  wire wr_trig = wr_i && (addr_i == bwp_pkg::ADDR_TRIG);
  wire wr_en = wr_i && (addr_i == bwp_pkg::ADDR_IRQ_EN);
  wire wr_clr = wr_i && (addr_i == bwp_pkg::ADDR_IRQ_CLR);
  // Indices that read back as zero: the clear register and the spare slot
  wire addr_void = (addr_i == bwp_pkg::ADDR_IRQ_CLR) || (addr_i == 3'h7);

  // ---------------------------------------------------------------
  // Line configuration decode, per bit n
  // ---------------------------------------------------------------
  // Bit n of every register meets only line n, so plain bitwise logic suffices
  wire [WIDTH-1:0] is_in = ~line_direction_reg_r;
  wire [WIDTH-1:0] pu_mode = is_in & ~pin_value_latch_r;
  wire [WIDTH-1:0] int_mode = is_in & line_option_sel_r & ~pin_value_latch_r;
  wire [WIDTH-1:0] ana_mode = is_in & line_option_sel_r & pin_value_latch_r & ANALOG_MASK[WIDTH-1:0];
  // Open-drain drives only a low; push-pull drives both levels
  wire [WIDTH-1:0] drive_en = line_direction_reg_r & (line_option_sel_r | ~pin_value_latch_r);
  // Input reads come from pins so software sees real levels
  wire [WIDTH-1:0] latch_view = (is_in & pin_i) | (line_direction_reg_r & pin_value_latch_r);

  // Pin side outputs decoded straight from the registers, except the request, which also gates with pin_i
  assign pullup_o = pu_mode;
  assign analog_sel_o = ana_mode;
  assign pin_oe_n_o = ~drive_en;
  // The latch shows on the pin even while released; the enable decides
  assign pin_o = pin_value_latch_r;
  assign irq_req_o = int_mode & pin_i;

  // ---------------------------------------------------------------
  // Trigger detection
  // ---------------------------------------------------------------
  // Edges compare with last cycle's level; inputs are already synchronous
  wire [WIDTH-1:0] fall_ev = pin_prev_r & ~pin_i;
  wire [WIDTH-1:0] rise_ev = ~pin_prev_r & pin_i;
  wire [WIDTH-1:0] low_ev = ~pin_i;
  // One trigger kind serves the whole port
  wire [WIDTH-1:0] trig_ev = (trig_r == bwp_pkg::TRIG_RISE) ? rise_ev :
                             (trig_r == bwp_pkg::TRIG_LOW) ? low_ev : fall_ev;
  // Only interrupt-configured lines may set status
  wire [WIDTH-1:0] event_v = trig_ev & int_mode;
  // Set wins over clear so an event in the clear cycle survives
  wire [WIDTH-1:0] clr_v = wr_clr ? wdata_i[WIDTH-1:0] : '0;
  assign stat_nxt = (stat_r & ~clr_v) | event_v;
  // Level output, drops as soon as status or enable clears
  assign irq_o = |(stat_r & en_r);

  // Port registers clear on reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_value_latch_r <= bwp_pkg::RST_PORT[WIDTH-1:0];
      line_direction_reg_r <= bwp_pkg::RST_PORT[WIDTH-1:0];
      line_option_sel_r <= bwp_pkg::RST_PORT[WIDTH-1:0];
    end else begin
      if (wr_latch) pin_value_latch_r <= wdata_i[WIDTH-1:0];
      if (wr_dir) line_direction_reg_r <= wdata_i[WIDTH-1:0];
      if (wr_opt) line_option_sel_r <= wdata_i[WIDTH-1:0];
    end
  end

  // Interrupt plumbing; previous levels start high to match the pulled-up idle pins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_r <= bwp_pkg::RST_TRIG;
      en_r <= '0;
      stat_r <= '0;
      pin_prev_r <= '1;
    end else begin
      if (wr_trig) trig_r <= wdata_i[1:0];
      if (wr_en) en_r <= wdata_i[WIDTH-1:0];
      stat_r <= stat_nxt;
      pin_prev_r <= pin_i;
    end
  end

  // ---------------------------------------------------------------
  // Read path, one cycle latency, unmapped reads zero
  // ---------------------------------------------------------------
  // Bits above WIDTH stay zero so narrow ports read clean
  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    unique case (addr_i)
      bwp_pkg::ADDR_LATCH: rsel[WIDTH-1:0] = latch_view;
      bwp_pkg::ADDR_DIR: rsel[WIDTH-1:0] = line_direction_reg_r;
      bwp_pkg::ADDR_OPT: rsel[WIDTH-1:0] = line_option_sel_r;
      bwp_pkg::ADDR_TRIG: rsel[1:0] = trig_r;
      bwp_pkg::ADDR_IRQ_STAT: rsel[WIDTH-1:0] = stat_r;
      bwp_pkg::ADDR_IRQ_EN: rsel[WIDTH-1:0] = en_r;
      default: rsel = 8'h00;
    endcase
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) rdata_o <= 8'h00;
    else if (rd_i) rdata_o <= rsel;
    else rdata_o <= 8'h00;
  end

  // ---------------------------------------------------------------
  // Port-wide checks
  // ---------------------------------------------------------------
  // Right after release the three port registers still hold their reset value
  chk_reset_inputs: assert property (@(posedge mclk_i)
    $fell(rst_i) |-> (pin_value_latch_r == bwp_pkg::RST_PORT[WIDTH-1:0] &&
    line_direction_reg_r == bwp_pkg::RST_PORT[WIDTH-1:0] &&
    line_option_sel_r == bwp_pkg::RST_PORT[WIDTH-1:0]))
    else $error("port registers not cleared by reset");
  // A data read returns the pin view of the cycle of the strobe
  chk_read_live: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && addr_i == bwp_pkg::ADDR_LATCH |=> rdata_o[WIDTH-1:0] == $past(latch_view))
    else $error("data read not live");
  // A data write lands in the latch at once
  chk_latch_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_latch |=> pin_value_latch_r == $past(wdata_i[WIDTH-1:0])) else $error("latch not written");
  // Direction and option writes land the same way
  chk_dir_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_dir |=> line_direction_reg_r == $past(wdata_i[WIDTH-1:0])) else $error("direction not written");
  chk_opt_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_opt |=> line_option_sel_r == $past(wdata_i[WIDTH-1:0])) else $error("option not written");
  // Nothing beyond the mapped registers answers a read
  chk_void_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && addr_void |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  // Read data is zero outside the cycle after a strobe
  chk_rdata_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 8'h00) else $error("read data outside its cycle");
  // The interrupt output rises with masked status on line 0 and stays low with no masked status
  chk_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    (stat_r[0] && en_r[0]) |-> irq_o) else $error("irq not raised");
  chk_irq_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((stat_r & en_r) == '0) |-> !irq_o) else $error("irq without cause");

  // ---------------------------------------------------------------
  // Per-line checks
  // ---------------------------------------------------------------
  // Each line is checked on its own, since each is set up on its own
  for (genvar n = 0; n < WIDTH; n++) begin : g_line_chk
    // Pull-up with no interrupt is the reset and default configuration
    chk_pullup_input: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!line_direction_reg_r[n] && !line_option_sel_r[n] && !pin_value_latch_r[n]) |->
      (pullup_o[n] && !irq_req_o[n] && !analog_sel_o[n] && pin_oe_n_o[n]))
      else $error("plain pull-up input wrong");
    // Data 1 on a plain input removes the pull-up
    chk_pullup_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!line_direction_reg_r[n] && pin_value_latch_r[n]) |-> !pullup_o[n])
      else $error("pull-up wrong");
    // Interrupt inputs keep the pull-up
    chk_int_pullup: assert property (@(posedge mclk_i) disable iff (rst_i)
      int_mode[n] |-> (pullup_o[n] && pin_oe_n_o[n])) else $error("interrupt input wrong");
    // Analog select follows the configuration on capable lines only
    chk_analog_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
      analog_sel_o[n] |-> (ANALOG_MASK[n] && !line_direction_reg_r[n] && line_option_sel_r[n] &&
      pin_value_latch_r[n])) else $error("analog select wrong");
    // Open drain releases the line for a high and pulls it for a low
    chk_opendrain_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
      (line_direction_reg_r[n] && !line_option_sel_r[n]) |-> (pin_oe_n_o[n] == pin_value_latch_r[n]))
      else $error("open drain wrong");
    // Push-pull always drives
    chk_pushpull_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
      (line_direction_reg_r[n] && line_option_sel_r[n]) |-> !pin_oe_n_o[n])
      else $error("push pull wrong");
    // Outputs carry no pull-up and no analog select
    chk_output_clean: assert property (@(posedge mclk_i) disable iff (rst_i)
      line_direction_reg_r[n] |-> (!pullup_o[n] && !analog_sel_o[n] && !irq_req_o[n]))
      else $error("output line has input extras");
    // The pin level is the latch bit of the same index
    chk_pin_level: assert property (@(posedge mclk_i) disable iff (rst_i)
      pin_o[n] == pin_value_latch_r[n]) else $error("pin level wrong");
    // Interrupt lines pass the pin, others stay inactive
    chk_req_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
      int_mode[n] |-> (irq_req_o[n] == pin_i[n])) else $error("request not the pin");
    chk_req_inactive: assert property (@(posedge mclk_i) disable iff (rst_i)
      !int_mode[n] |-> !irq_req_o[n]) else $error("stray request");
    // A status bit holds until cleared, and an event beats a clear
    chk_event_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
      event_v[n] |=> stat_r[n]) else $error("event lost");
    chk_stat_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wr_clr && wdata_i[n] && !event_v[n]) |=> !stat_r[n]) else $error("status not cleared");
    chk_stat_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
      (stat_r[n] && !wr_clr) |=> stat_r[n]) else $error("status dropped");
    // No status without an interrupt-configured line
    chk_stat_source: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!stat_r[n] && !int_mode[n]) |=> !stat_r[n]) else $error("status from idle line");
  end

  // Main scenarios worth seeing at least once
  cov_analog: cover property (@(posedge mclk_i) analog_sel_o[0]);
  cov_irq: cover property (@(posedge mclk_i) irq_o);
  cov_pushpull: cover property (@(posedge mclk_i) line_direction_reg_r[0] && line_option_sel_r[0]);
  cov_opendrain: cover property (@(posedge mclk_i) line_direction_reg_r[0] && !line_option_sel_r[0]);
endmodule // bwp_port

// *** bench/bwp_pin_model.sv ***
`timescale 1ns/10ps
// Board side of the port: device drive, an external source, pull-ups
module bwp_pin_model (
  // Device side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] pullup_o,
  // Board side
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] level_o
);
  logic [7:0] float_r = 8'h00;
  // A floating line wanders, so nobody can lean on a stale level
  always #7 float_r = ~float_r;
  // Device drive wins, then the board source, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level_o[i] = !pin_oe_n_o[i] ? pin_o[i] : ext_en_i[i] ? ext_val_i[i] : pullup_o[i] ? 1'b1 : float_r[i];
    end
  end
endmodule // bwp_pin_model

// *** bench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] AMASK = 8'h3C;
  logic mclk_i, rst_i, wr_i, rd_i, irq_o, rd_d;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pin_i, pin_o, pin_oe_n_o, pullup_o, analog_sel_o, irq_req_o;
  logic [7:0] ext_en, ext_val, d, dv, op, ev, an;
  logic [1:0] tr [3] = '{bwp_pkg::TRIG_FALL, bwp_pkg::TRIG_RISE, bwp_pkg::TRIG_LOW};
  logic [7:0] q [$];
  int num_errors = 0, cmp_count = 0;
  bwp_port #(.WIDTH(8), .ANALOG_MASK(AMASK)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o), .analog_sel_o(analog_sel_o), .irq_req_o(irq_req_o), .irq_o(irq_o));
  bwp_pin_model board (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pin_i));
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One access then an idle edge, so a strobe is never assigned twice at once
  task automatic acc(input bit w, input logic [2:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= w;
    rd_i <= !w;
    if (!w) q.push_back(v);
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_i) begin
    if (rd_d === 1'b1 && q.size() > 0) chk(rdata_o, q.pop_front(), "read data");
    rd_d <= rd_i;
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {addr_i, wdata_i, wr_i, rd_i, rd_d, ext_en, ext_val} = '0;
    rst_i = 1'b1;
    void'($urandom(24));
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk(pullup_o, 8'hFF, "reset pull-up");
    chk(pin_oe_n_o, 8'hFF, "reset drive");
    acc(0, bwp_pkg::ADDR_DIR, 8'h00);
    acc(0, bwp_pkg::ADDR_OPT, 8'h00);
    acc(0, bwp_pkg::ADDR_LATCH, 8'hFF);
    for (int n = 0; n < 8; n++) begin
      {d, dv, op, ev} = $urandom;
      an = ~dv & op & d;
      op = op ^ (an & ~(an & (~an + 8'h01)));
      ev = ev | (dv & ~op & d);
      ext_en <= 8'hFF;
      ext_val <= ev;
      acc(1, bwp_pkg::ADDR_LATCH, d);
      acc(1, bwp_pkg::ADDR_DIR, dv);
      acc(1, bwp_pkg::ADDR_OPT, op);
      acc(0, bwp_pkg::ADDR_DIR, dv);
      acc(0, bwp_pkg::ADDR_OPT, op);
      acc(0, bwp_pkg::ADDR_LATCH, (~dv & ev) | (dv & d));
      chk(pin_oe_n_o, ~(dv & (op | ~d)), "drive");
      chk(pin_o & dv, d & dv, "level");
      chk(pullup_o, ~dv & ~d, "pull-up");
      chk(analog_sel_o, ~dv & op & d & AMASK, "analog");
      chk(irq_req_o, ~dv & op & ~d & ev, "request");
    end
    acc(1, bwp_pkg::ADDR_DIR, 8'h00);
    acc(1, bwp_pkg::ADDR_OPT, 8'h01);
    acc(1, bwp_pkg::ADDR_LATCH, 8'h00);
    acc(1, bwp_pkg::ADDR_IRQ_EN, 8'h01);
    // Each trigger kind: settle on the quiet level, then give the event
    for (int t = 0; t < 3; t++) begin
      ext_val <= (tr[t] == bwp_pkg::TRIG_RISE) ? 8'h00 : 8'h01;
      acc(1, bwp_pkg::ADDR_TRIG, {6'h00, tr[t]});
      acc(0, bwp_pkg::ADDR_TRIG, {6'h00, tr[t]} & 8'h03);
      acc(1, bwp_pkg::ADDR_IRQ_CLR, 8'hFF);
      acc(1, bwp_pkg::ADDR_IRQ_CLR, 8'hFF);
      chk({7'h00, irq_o}, 8'h00, "irq idle");
      ext_val <= (tr[t] == bwp_pkg::TRIG_RISE) ? 8'h01 : 8'h00;
      for (int k = 0; k < 20 && irq_o !== 1'b1; k++) @(posedge mclk_i);
      chk({7'h00, irq_o}, 8'h01, "irq raise");
      if (irq_o !== 1'b1) conclude();
      acc(0, bwp_pkg::ADDR_IRQ_STAT, 8'h01);
      acc(1, bwp_pkg::ADDR_IRQ_EN, 8'h00);
      chk({7'h00, irq_o}, 8'h00, "irq masked");
      acc(1, bwp_pkg::ADDR_IRQ_EN, 8'h01);
    end
    acc(0, 3'h7, 8'h00);
    conclude();
  end
endmodule // testbench
